// >>> core/lpcm_regs.svh
// constants for the low-power clock mode controller
`ifndef LPCM_REGS_SVH
`define LPCM_REGS_SVH
// divider select encodings for the two-bit field
`define LPCM_DIV_NONE    2'h0
`define LPCM_DIV_BY2     2'h1
`define LPCM_DIV_BY4     2'h2
`define LPCM_DIV_BY16    2'h3
// divide ratios
`define LPCM_RATIO_2     5'h02
`define LPCM_RATIO_4     5'h04
`define LPCM_RATIO_8     5'h08
`define LPCM_RATIO_16    5'h10
`define LPCM_RATIO_32    6'h20
// reset value of main divide select zero
`define LPCM_DIVSEL0_RST 1'b1
// oscillator restart settle time after stop exit
`define LPCM_SETTLE_NS   1600
`define LPCM_CLK_NS      100
`define LPCM_SETTLE_CYC  ((`LPCM_SETTLE_NS + `LPCM_CLK_NS - 1) / `LPCM_CLK_NS)
// clock output source select
`define LPCM_CO_SUB      2'h0
`define LPCM_CO_DIV8     2'h1
`define LPCM_CO_DIV32    2'h2
`endif

// >>> core/lpcm_pkg.sv
// types for the low-power clock mode controller
package lpcm_pkg;
	// power state, gray coded along run-wait-stop-wake
	typedef enum logic [1:0] {
		LPCM_RUN  = 2'b00,
		LPCM_WAIT = 2'b01,
		LPCM_STOP = 2'b11,
		LPCM_WAKE = 2'b10
	} lpcm_state_t;

	// external bus pins guarded in low-power states
	typedef struct packed {
		logic [15:0] address;
		logic [15:0] data;
		logic [3:0]  chip_select_line;
		logic        byte_high_enable;
		logic        read_strobe;
		logic        write_strobe;
		logic        write_low_strobe;
		logic        write_high_strobe;
		logic        hold_acknowledge;
		logic        bus_clock;
		logic        latch_enable;
	} lpcm_bus_t;

	// clock gate enables to the rest of the chip
	typedef struct packed {
		logic system_clock;
		logic peripheral;
		logic serial_peripheral_clock;
		logic subclock_direct;
		logic subclock_div32;
		logic converter_clock;
		logic watchdog;
		logic main_osc;
		logic sub_osc;
	} lpcm_gates_t;
endpackage

// >>> core/lpcm_ctrl.sv
// low-power state and system clock divider control
`timescale 1ns/1ns
`include "lpcm_regs.svh"
module lpcm_ctrl #(
	parameter int SETTLE_CYC = `LPCM_SETTLE_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	input  wire logic                 all_clock_halt_wr,
	input  wire logic                 wait_instr,
	input  wire logic                 wait_periph_halt,
	input  wire logic                 irq_wake,
	input  wire logic                 subclock_select,
	input  wire logic                 main_clock_halt,
	input  wire logic                 divsel_wr,
	input  wire logic                 divsel_zero_in,
	input  wire logic [1:0]           divsel_field_in,
	input  wire logic                 ext_bus_mode,
	input  wire logic [1:0]           clock_out_select,
	input  wire logic                 subclock_tick,
	input  wire logic                 timer_ext_event,
	input  wire logic                 serial_ext_clock,
	input  wire lpcm_pkg::lpcm_bus_t  bus_in,
	input  wire logic [7:0]           port_in,
	output lpcm_pkg::lpcm_bus_t       bus_out,
	output logic [7:0]                port_out,
	output logic                      clock_output_pin,
	output lpcm_pkg::lpcm_gates_t     gates,
	output logic                      system_clock_tick,
	output logic                      peripheral_clock_div8,
	output logic                      peripheral_clock_div32,
	output logic                      timer_ext_count,
	output logic                      serial_ext_run,
	output logic                      irq_service,
	output logic                      main_divide_select_zero,
	output logic [1:0]                divide_select,
	output lpcm_pkg::lpcm_state_t     power_state
);
	import lpcm_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// ratio chosen by the divider controls
	function automatic logic [4:0] div_ratio(input logic sel0, input logic [1:0] fld);
		if (sel0) begin
			div_ratio = `LPCM_RATIO_8;
		end else begin
			case (fld)
				`LPCM_DIV_NONE: div_ratio = 5'h01;
				`LPCM_DIV_BY2:  div_ratio = `LPCM_RATIO_2;
				`LPCM_DIV_BY4:  div_ratio = `LPCM_RATIO_4;
				default:        div_ratio = `LPCM_RATIO_16;
			endcase
		end
	endfunction

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	lpcm_state_t state;
	lpcm_state_t next_state;
	logic [15:0] settle;
	logic [15:0] next_settle;
	logic        divsel0;
	logic        next_divsel0;
	logic [1:0]  divfld;
	logic [1:0]  next_divfld;
	logic        wait_halt;
	logic        next_wait_halt;
	logic        service;
	logic        next_service;

	// transitions; reset is the synchronous rst_b itself
	always_comb begin
		next_state     = state;
		next_settle    = settle;
		next_divsel0   = divsel0;
		next_divfld    = divfld;
		next_wait_halt = wait_halt;
		next_service   = 1'b0;
		case (state)
			LPCM_RUN: begin
				if (divsel_wr) begin
					next_divsel0 = divsel_zero_in;
					next_divfld  = divsel_field_in;
				end
				if (all_clock_halt_wr) begin
					next_state = LPCM_STOP;
					if (!subclock_select) begin
						next_divsel0 = 1'b1;
					end
				end else if (wait_instr) begin
					next_state     = LPCM_WAIT;
					next_wait_halt = wait_periph_halt;
				end
			end
			LPCM_WAIT: begin
				if (irq_wake) begin
					// divider regs untouched so the entry clock returns
					next_state     = LPCM_RUN;
					next_wait_halt = 1'b0;
					next_service   = 1'b1;
				end
			end
			LPCM_STOP: begin
				if (irq_wake) begin
					next_state  = LPCM_WAKE;
					next_settle = 16'(SETTLE_CYC);
				end
			end
			LPCM_WAKE: begin
				// hold the processor clock off while oscillators settle
				if (settle <= 16'h0001) begin
					next_state   = LPCM_RUN;
					next_settle  = 16'h0000;
					next_service = 1'b1;
				end else begin
					next_settle = settle - 16'h0001;
				end
			end
			default: next_state = LPCM_RUN;
		endcase
	end

	// registers, frozen while clk_en is low
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state     <= LPCM_RUN;
			settle    <= 16'h0000;
			divsel0   <= `LPCM_DIVSEL0_RST;
			divfld    <= `LPCM_DIV_NONE;
			wait_halt <= 1'b0;
			service   <= 1'b0;
		end else if (clk_en) begin
			state     <= next_state;
			settle    <= next_settle;
			divsel0   <= next_divsel0;
			divfld    <= next_divfld;
			wait_halt <= next_wait_halt;
			service   <= next_service;
		end
	end

	// ----------------------------------------
	// dividers
	// ----------------------------------------
	logic [4:0] sys_cnt;
	logic [4:0] next_sys_cnt;
	logic [4:0] per_cnt;
	logic [4:0] next_per_cnt;
	logic       sys_tick;
	logic       next_sys_tick;
	logic       p8;
	logic       next_p8;
	logic       p32;
	logic       next_p32;
	logic       co;
	logic       next_co;
	logic       run_sys;
	logic       run_per;

	// system clock only in run; peripherals also in wait without halt
	assign run_sys = (state == LPCM_RUN);
	assign run_per = run_sys || (state == LPCM_WAIT && !wait_halt);

	// tick generation: sub-clock tick when subclock selected
	always_comb begin
		next_sys_cnt  = sys_cnt;
		next_sys_tick = 1'b0;
		next_per_cnt  = per_cnt;
		next_p8       = p8;
		next_p32      = p32;
		if (run_sys) begin
			if (subclock_select) begin
				next_sys_tick = subclock_tick;
			end else if (sys_cnt + 5'h01 >= div_ratio(divsel0, divfld)) begin
				next_sys_cnt  = 5'h00;
				next_sys_tick = 1'b1;
			end else begin
				next_sys_cnt = sys_cnt + 5'h01;
			end
		end
		if (run_per) begin
			next_per_cnt = per_cnt + 5'h01;
			next_p8      = next_per_cnt[2];
			next_p32     = next_per_cnt[4];
		end
		// clock output pin
		next_co = co;
		case (clock_out_select)
			`LPCM_CO_SUB: begin
				if (state == LPCM_STOP || state == LPCM_WAKE) begin
					next_co = 1'b1;
				end else if (subclock_tick) begin
					next_co = ~co;
				end
			end
			`LPCM_CO_DIV8:  next_co = run_per ? next_p8 : co;
			`LPCM_CO_DIV32: next_co = run_per ? next_p32 : co;
			default:        next_co = co;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sys_cnt  <= 5'h00;
			sys_tick <= 1'b0;
			per_cnt  <= 5'h00;
			p8       <= 1'b0;
			p32      <= 1'b0;
			co       <= 1'b0;
		end else if (clk_en) begin
			sys_cnt  <= next_sys_cnt;
			sys_tick <= next_sys_tick;
			per_cnt  <= next_per_cnt;
			p8       <= next_p8;
			p32      <= next_p32;
			co       <= next_co;
		end
	end

	// ----------------------------------------
	// pin hold in low-power states
	// ----------------------------------------
	lpcm_bus_t bus_q;
	lpcm_bus_t next_bus_q;
	logic [7:0] port_q;
	logic [7:0] next_port_q;
	logic       low_power;

	assign low_power = (state != LPCM_RUN);

	// capture live values while running, freeze otherwise; in external bus mode strobes are forced
	// from the entry edge on, so no cycle of the low-power state shows them low
	always_comb begin
		next_bus_q  = low_power ? bus_q : bus_in;
		next_port_q = low_power ? port_q : port_in;
		if (next_state != LPCM_RUN && ext_bus_mode) begin
			next_bus_q.read_strobe       = 1'b1;
			next_bus_q.write_strobe      = 1'b1;
			next_bus_q.write_low_strobe  = 1'b1;
			next_bus_q.write_high_strobe = 1'b1;
			next_bus_q.hold_acknowledge  = 1'b1;
			next_bus_q.bus_clock         = 1'b1;
			next_bus_q.latch_enable      = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_q  <= '0;
			port_q <= 8'h00;
		end else if (clk_en) begin
			bus_q  <= next_bus_q;
			port_q <= next_port_q;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// gate enables follow the registered state
	always_comb begin
		gates.system_clock            = run_sys;
		gates.peripheral              = run_per;
		gates.serial_peripheral_clock = run_per;
		gates.subclock_direct         = (state != LPCM_STOP);
		gates.subclock_div32          = (state != LPCM_STOP);
		gates.converter_clock         = run_per;
		gates.watchdog                = run_sys;
		gates.main_osc                = (state != LPCM_STOP)
		                                && !(subclock_select && main_clock_halt);
		gates.sub_osc                 = (state != LPCM_STOP);
	end

	assign bus_out                 = bus_q;
	assign port_out                = port_q;
	assign clock_output_pin        = co;
	assign system_clock_tick       = sys_tick;
	assign peripheral_clock_div8   = p8;
	assign peripheral_clock_div32  = p32;
	assign timer_ext_count         = timer_ext_event;
	assign serial_ext_run          = serial_ext_clock;
	assign irq_service             = service;
	assign main_divide_select_zero = divsel0;
	assign divide_select           = divfld;
	assign power_state             = state;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_stop_entry;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_RUN && all_clock_halt_wr) |=> state == LPCM_STOP;
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

	property p_stop_gates;
		@(posedge clk) disable iff (!rst_b)
		state == LPCM_STOP |-> !gates.system_clock && !gates.converter_clock
		                       && !gates.watchdog && !gates.main_osc;
	endproperty
	a_stop_gates: assert property (p_stop_gates) else $error("clock live in stop");

	property p_wake_settle;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_STOP && irq_wake) |=> !gates.system_clock[*2];
	endproperty
	a_wake_settle: assert property (p_wake_settle) else $error("early clock");

	property p_divsel_stop;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_RUN && all_clock_halt_wr && !subclock_select)
		|=> divsel0;
	endproperty
	a_divsel_stop: assert property (p_divsel_stop) else $error("sel0 not set");

	property p_wait_entry;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_RUN && !all_clock_halt_wr && wait_instr)
		|=> state == LPCM_WAIT && !gates.watchdog && gates.main_osc == !(subclock_select
		&& main_clock_halt);
	endproperty
	a_wait_entry: assert property (p_wait_entry) else $error("bad wait entry");

	property p_wait_halt;
		@(posedge clk) disable iff (!rst_b)
		(state == LPCM_WAIT && wait_halt) |-> !gates.peripheral && gates.subclock_div32;
	endproperty
	a_wait_halt: assert property (p_wait_halt) else $error("periph not gated");

	property p_wait_exit;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_WAIT && irq_wake)
		|=> state == LPCM_RUN && irq_service && $stable(divsel0) && $stable(divfld);
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("bad wait exit");

	property p_strobes_high;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && low_power && ext_bus_mode)
		|=> bus_out.read_strobe && bus_out.bus_clock && bus_out.latch_enable;
	endproperty
	a_strobes_high: assert property (p_strobes_high) else $error("strobe low");

	property p_ports_hold;
		@(posedge clk) disable iff (!rst_b)
		(low_power && $past(low_power)) |-> $stable(port_out);
	endproperty
	a_ports_hold: assert property (p_ports_hold) else $error("port moved");

	property p_co_stop;
		@(posedge clk) disable iff (!rst_b)
		(clk_en && state == LPCM_STOP && clock_out_select == `LPCM_CO_SUB)
		|=> clock_output_pin;
	endproperty
	a_co_stop: assert property (p_co_stop) else $error("clock out not high");
endmodule

// >>> test/lpcm_core_model.sv
// core and interrupt controller model issuing low-power requests
`timescale 1ns/1ns
module lpcm_core_model (
	input  wire logic                  clk,
	input  wire logic                  subclock_select,
	input  wire lpcm_pkg::lpcm_state_t power_state,
	output logic                       all_clock_halt_wr,
	output logic                       wait_instr,
	output logic                       wait_periph_halt,
	output logic                       irq_wake
);
	import lpcm_pkg::*;
	// set while every non-waking interrupt priority is zero
	logic prio_zero;

	initial begin
		all_clock_halt_wr = 1'b0;
		wait_instr = 1'b0;
		wait_periph_halt = 1'b0;
		irq_wake = 1'b0;
		prio_zero = 1'b0;
	end

	// ---------------------------------------------
	// requests after a falling edge; halt and wait are one cycle pulses, wake is held
	// ---------------------------------------------
	task automatic issue_halt();
		@(negedge clk);
		prio_zero = 1'b1;
		all_clock_halt_wr = 1'b1;
		@(negedge clk);
		all_clock_halt_wr = 1'b0;
	endtask

	task automatic issue_wait(input logic halt_bit);
		@(negedge clk);
		prio_zero = 1'b1;
		// never halts peripherals while running on the subclock
		wait_periph_halt = halt_bit & ~subclock_select;
		wait_instr = 1'b1;
		@(negedge clk);
		wait_instr = 1'b0;
	endtask

	// wake request held until the controller has left stop or wait, for at most eight cycles
	task automatic issue_wake();
		int i;
		@(negedge clk);
		// only wake once the other priorities have been zeroed
		irq_wake = prio_zero;
		for (i = 0; i < 8 && (power_state == LPCM_STOP || power_state == LPCM_WAIT); i++)
			@(negedge clk);
		irq_wake = 1'b0;
		prio_zero = 1'b0;
	endtask
endmodule

// >>> test/lpcm_ctrl_tb.sv
// self-checking bench for the low-power clock mode controller
`timescale 1ns/1ns
module lpcm_ctrl_tb;
	import lpcm_pkg::*;
	logic        clk, rst_b, clk_en, all_clock_halt_wr, wait_instr, wait_periph_halt, irq_wake;
	logic        subclock_select, main_clock_halt, divsel_wr, divsel_zero_in, ext_bus_mode;
	logic        subclock_tick, timer_ext_event, serial_ext_clock, clock_output_pin;
	logic        system_clock_tick, peripheral_clock_div8, peripheral_clock_div32;
	logic        timer_ext_count, serial_ext_run, irq_service, main_divide_select_zero;
	logic [1:0]  divsel_field_in, clock_out_select, divide_select;
	logic [7:0]  port_in, port_out;
	lpcm_bus_t   bus_in, bus_out;
	lpcm_gates_t gates;
	lpcm_state_t power_state;
	int          n_fail, tests_run, cyc, n, f;
	int          ratio[4] = '{1, 2, 4, 16};

	lpcm_ctrl #(.SETTLE_CYC(2)) u_dut (.clk, .rst_b, .clk_en, .all_clock_halt_wr, .wait_instr,
		.wait_periph_halt, .irq_wake, .subclock_select, .main_clock_halt, .divsel_wr,
		.divsel_zero_in, .divsel_field_in, .ext_bus_mode, .clock_out_select, .subclock_tick,
		.timer_ext_event, .serial_ext_clock, .bus_in, .port_in, .bus_out, .port_out,
		.clock_output_pin, .gates, .system_clock_tick, .peripheral_clock_div8,
		.peripheral_clock_div32, .timer_ext_count, .serial_ext_run, .irq_service,
		.main_divide_select_zero, .divide_select, .power_state);
	lpcm_core_model u_core (.clk, .subclock_select, .power_state, .all_clock_halt_wr,
		.wait_instr, .wait_periph_halt, .irq_wake);

	// ---------------------------------------------
	// clock, sub-clock ticks and run limit
	// ---------------------------------------------
	initial clk = 1'b0;
	always #50 clk = ~clk;
	always @(negedge clk) subclock_tick <= (cyc[2:0] == 3'h0);
	// generous limit, the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			$display("mismatch at %0t: run too long", $time);
			complete_run();
		end
	end

	// ---------------------------------------------
	// compare and access tasks
	// ---------------------------------------------
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task automatic wait_state(input lpcm_state_t s);
		int i;
		for (i = 0; i < 20 && power_state !== s; i++) @(negedge clk);
		cmp(power_state, s, "power state");
	endtask

	task automatic set_div(input logic z, input logic [1:0] fld);
		divsel_wr = 1'b1;
		divsel_zero_in = z;
		divsel_field_in = fld;
		@(negedge clk);
		divsel_wr = 1'b0;
		@(negedge clk);
	endtask

	// cycles from one system tick to the next
	task automatic tick_gap(output int g);
		int i;
		for (i = 0; i < 40 && system_clock_tick !== 1'b1; i++) @(negedge clk);
		for (g = 1; g < 40; g++) begin
			@(negedge clk);
			if (system_clock_tick === 1'b1) break;
		end
	endtask

	task automatic chk_ratio(input int r);
		int g;
		tick_gap(g);
		tick_gap(g);
		cmp(g, r, "divided period");
	endtask

	task automatic count_toggles(output int t);
		logic last;
		int i;
		t = 0;
		last = clock_output_pin;
		for (i = 0; i < 80; i++) begin
			@(negedge clk);
			if (clock_output_pin !== last) t++;
			last = clock_output_pin;
		end
	endtask

	task automatic complete_run();
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		{rst_b, divsel_wr, divsel_zero_in, divsel_field_in, ext_bus_mode} = '0;
		{subclock_select, main_clock_halt, clock_out_select, timer_ext_event} = '0;
		{serial_ext_clock, subclock_tick, port_in, n_fail, tests_run, cyc} = '0;
		bus_in = '0;
		clk_en = 1'b1;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		cmp(power_state, LPCM_RUN, "state after reset");
		cmp(main_divide_select_zero, 1'b1, "select zero after reset");
		chk_ratio(8);
		// every divider field with select zero clear
		for (f = 0; f < 4; f++) begin
			set_div(1'b0, f[1:0]);
			chk_ratio(ratio[f]);
		end
		// stop from a main-clock mode with the external bus active
		ext_bus_mode = 1'b1;
		port_in = 8'h5a;
		bus_in.address = 16'h1234;
		timer_ext_event = 1'b1;
		repeat (2) @(negedge clk);
		u_core.issue_halt();
		wait_state(LPCM_STOP);
		cmp(gates, '0, "gates in stop");
		port_in = 8'ha5;
		bus_in.address = 16'h4321;
		serial_ext_clock = 1'b1;
		@(negedge clk);
		cmp(port_out, 8'h5a, "port hold");
		cmp(bus_out.address, 16'h1234, "address hold");
		cmp({bus_out.read_strobe, bus_out.hold_acknowledge}, 2'h3, "strobes high");
		cmp({bus_out.bus_clock, bus_out.latch_enable}, 2'h3, "bus clock high");
		cmp({timer_ext_count, serial_ext_run}, 2'h3, "external counting");
		u_core.issue_wake();
		cmp(power_state, LPCM_WAKE, "settling");
		cmp(gates.system_clock, 1'b0, "clock held while settling");
		wait_state(LPCM_RUN);
		cmp(irq_service, 1'b1, "service after stop");
		cmp(main_divide_select_zero, 1'b1, "select zero set by stop");
		chk_ratio(8);
		// subclock modes: main oscillator halt, then stop keeps select zero
		set_div(1'b0, 2'h0);
		{ext_bus_mode, subclock_select, main_clock_halt} = 3'h3;
		repeat (3) @(negedge clk);
		cmp({gates.main_osc, gates.sub_osc}, 2'h1, "main oscillator off");
		main_clock_halt = 1'b0;
		u_core.issue_halt();
		wait_state(LPCM_STOP);
		cmp(clock_output_pin, 1'b1, "clock out high in stop");
		u_core.issue_wake();
		wait_state(LPCM_RUN);
		cmp(main_divide_select_zero, 1'b0, "select zero kept");
		cmp(divide_select, 2'h0, "divider field kept");
		// wait with peripherals running, div8 on the clock output pin
		subclock_select = 1'b0;
		clock_out_select = 2'h1;
		u_core.issue_wait(1'b0);
		wait_state(LPCM_WAIT);
		cmp({gates.system_clock, gates.watchdog}, 2'h0, "wait clock off");
		cmp({gates.main_osc, gates.sub_osc}, 2'h3, "oscillators run");
		count_toggles(n);
		cmp(n > 0, 1'b1, "clock out runs in wait");
		u_core.issue_wake();
		wait_state(LPCM_RUN);
		cmp(irq_service, 1'b1, "service after wait");
		chk_ratio(1);
		// wait with peripheral halt: peripheral clock off, subclock div32 still on
		u_core.issue_wait(1'b1);
		wait_state(LPCM_WAIT);
		cmp({gates.peripheral, gates.subclock_div32}, 2'h1, "peripheral halt");
		count_toggles(n);
		cmp(n, 0, "clock out held in wait");
		u_core.issue_wake();
		wait_state(LPCM_RUN);
		complete_run();
	end
endmodule
